// *** stp_defs.vh ***
// Register map, field positions and reset values of the SPI transaction sequencer
`ifndef STP_DEFS_VH
`define STP_DEFS_VH

// Byte offsets on the register bus
`define STP_OFF_GO       8'h00
`define STP_OFF_CTRL     8'h1c
`define STP_OFF_PLEN     8'h20
`define STP_OFF_CMDCFG   8'h24
`define STP_OFF_TXLEN    8'h28
`define STP_OFF_RXLEN    8'h2c
`define STP_OFF_STATUS   8'h30
`define STP_OFF_ADDR     8'h38
`define STP_OFF_TIMING   8'h3c
`define STP_BUF_SEL      2'h2

// Go register: write 1 starts, reads back busy
`define STP_GO_BIT       18

// transaction_control bits
`define STP_CMD_EN       31
`define STP_ADDR_EN      30
`define STP_DUMMY_EN     29
`define STP_RX_EN        28
`define STP_TX_EN        27
`define STP_DUMMY_GATE   26
`define STP_TX_HI        25
`define STP_RX_HI        24
`define STP_THREE_WIRE   16
`define STP_QUAD_AD      15
`define STP_DUAL_AD      14
`define STP_QUAD_D       13
`define STP_DUAL_D       12
`define STP_TX_BE        11
`define STP_RX_BE        10
`define STP_OUT_EDGE     7
`define STP_IN_EDGE      6
`define STP_CS_SETUP     5
`define STP_CS_HOLD      4
`define STP_FULL_DUPLEX  0
`define STP_CTRL_MASK    32'hff01_fcf1
`define STP_CTRL_RST     32'h8000_0040

// Field positions of the length and timing registers
`define STP_ADDR_LEN_LSB 26
`define STP_CMD_LEN_LSB  28
`define STP_PLEN_MASK    32'h0000_00ff
`define STP_CMDCFG_MASK  32'hf000_ffff
`define STP_LEN_MASK     32'h0000_01ff
`define STP_TIM_HOLD     8
`define STP_TIM_DIV      16
`define STP_TIM_TXDLY    24
`define STP_TIM_RXDLY    26
`define STP_TIM_SLAVE    28
`define STP_TIM_MASK     32'h1fff_ffff
`define STP_TIM_RST      32'h0004_0000

`endif

// *** stp_spi_sequencer.v ***
// SPI transaction sequencer: phase control, data buffer and Avalon-MM registers
`include "stp_defs.vh"
`default_nettype none

module stp_spi_sequencer #(
	parameter ADDR_BITS = 24
) (
	input  wire        core_clk,
	input  wire        reset,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire        avs_waitrequest,
	output reg  [31:0] avs_readdata,
	output reg         spi_sclk,
	output reg         spi_cs_n,
	output reg  [3:0]  spi_io_out,
	output reg  [3:0]  spi_io_oe,
	input  wire [3:0]  spi_io_in,
	output wire        busy
);

	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_SETUP = 4'h1;
	localparam [3:0] ST_CMD   = 4'h2;
	localparam [3:0] ST_ADDR  = 4'h3;
	localparam [3:0] ST_DUMMY = 4'h4;
	localparam [3:0] ST_TXD   = 4'h5;
	localparam [3:0] ST_RXD   = 4'h6;
	localparam [3:0] ST_HOLD  = 4'h7;
	localparam [3:0] ST_DONE  = 4'h8;
	localparam integer ADDR_LEN_I = ADDR_BITS - 1;
	localparam [5:0] ADDR_LEN_M1 = ADDR_LEN_I[5:0];

	reg  [31:0] ctrl_ff;
	reg  [31:0] plen_ff;
	reg  [31:0] cmdcfg_ff;
	reg  [31:0] txlen_ff;
	reg  [31:0] rxlen_ff;
	reg  [31:0] status_ff;
	reg  [31:0] addr_ff;
	reg  [31:0] timing_ff;
	reg  [31:0] buf_ff [0:15];
	reg  [3:0]  st_ff;
	reg  [9:0]  cnt_ff;
	reg         half_ff;
	reg  [7:0]  div_ff;
	reg         ack_ff;
	reg  [3:0]  io_meta_ff;
	reg  [3:0]  io_sync_ff;
	reg  [3:0]  pipe_ff;
	reg  [3:0]  rx_pipe_ff;
	reg  [31:0] nxt_rdata;
	reg  [9:0]  len_cur;
	reg  [2:0]  w_cur;
	reg  [3:0]  tx_bits;
	integer     j;
	integer     r; // Buffer loop index, kept apart from the lane loop

	// Configuration fields
	wire       cmd_en     = ctrl_ff[`STP_CMD_EN];
	wire       addr_en    = ctrl_ff[`STP_ADDR_EN];
	wire       dummy_en   = ctrl_ff[`STP_DUMMY_EN];
	wire       rx_en      = ctrl_ff[`STP_RX_EN];
	wire       tx_en      = ctrl_ff[`STP_TX_EN];
	wire       dummy_gate = ctrl_ff[`STP_DUMMY_GATE];
	wire       tx_hi      = ctrl_ff[`STP_TX_HI];
	wire       rx_hi      = ctrl_ff[`STP_RX_HI];
	wire       three_wire = ctrl_ff[`STP_THREE_WIRE];
	wire       quad_ad    = ctrl_ff[`STP_QUAD_AD];
	wire       dual_ad    = ctrl_ff[`STP_DUAL_AD];
	wire       quad_d     = ctrl_ff[`STP_QUAD_D];
	wire       dual_d     = ctrl_ff[`STP_DUAL_D];
	wire       tx_be      = ctrl_ff[`STP_TX_BE];
	wire       rx_be      = ctrl_ff[`STP_RX_BE];
	wire       fd         = ctrl_ff[`STP_FULL_DUPLEX];
	wire       slave      = timing_ff[`STP_TIM_SLAVE];
	wire [7:0] setup_time = timing_ff[7:0];
	wire [7:0] hold_time  = timing_ff[`STP_TIM_HOLD+7:`STP_TIM_HOLD];
	wire [7:0] div_val    = timing_ff[`STP_TIM_DIV+7:`STP_TIM_DIV];
	wire [1:0] txm        = timing_ff[`STP_TIM_TXDLY+1:`STP_TIM_TXDLY];
	wire [1:0] rxm        = timing_ff[`STP_TIM_RXDLY+1:`STP_TIM_RXDLY];
	wire [3:0] cmd_len    = cmdcfg_ff[`STP_CMD_LEN_LSB+3:`STP_CMD_LEN_LSB];

	// Lane counts per phase
	wire [2:0] addr_w = quad_ad ? 3'd4 : (dual_ad ? 3'd2 : 3'd1);
	wire [2:0] data_w = (quad_ad | quad_d) ? 3'd4 :
		((dual_ad | dual_d) ? 3'd2 : 3'd1);

	// Long addresses borrow the status word as their low half
	wire [63:0] addr64 = (ADDR_LEN_M1 > 6'd31) ? {addr_ff, status_ff}
		: {32'h0000_0000, addr_ff};

	// Edge select: output edge in master mode, input edge in slave mode
	wire edge_sel = slave ? ctrl_ff[`STP_IN_EDGE] : ctrl_ff[`STP_OUT_EDGE];
	wire tx_half  = (txm == 2'd1 && edge_sel) || (txm == 2'd2 && !edge_sel);
	wire tx_full  = (txm != 2'd0) && !tx_half;
	wire rx_half  = (rxm == 2'd1 && edge_sel) || (rxm == 2'd2 && !edge_sel);
	wire rx_full  = (rxm != 2'd0) && !rx_half;

	// Bus handshake: every access waits exactly one cycle
	wire bus_req = avs_read | avs_write;
	wire wr      = avs_write & ack_ff;
	wire [5:0] widx = avs_address[7:2];
	wire cfg_wr  = wr & ~busy; // Config is frozen during a transaction
	assign avs_waitrequest = bus_req & ~ack_ff;
	assign busy = (st_ff != ST_IDLE);

	wire go = wr && ({widx, 2'b00} == `STP_OFF_GO) && avs_byteenable[2]
		&& avs_writedata[`STP_GO_BIT] && (st_ff == ST_IDLE);

	// Phase timing
	wire active  = (st_ff != ST_IDLE) && (st_ff != ST_DONE);
	wire tick    = active && (({1'b0, div_ff} + 9'd1) >= {1'b0, div_val});
	wire last    = ({1'b0, cnt_ff} + {8'h00, w_cur}) > {1'b0, len_cur};
	wire clocked = (st_ff >= ST_CMD) && (st_ff <= ST_RXD)
		&& !((st_ff == ST_DUMMY) && dummy_gate);
	wire rx_act  = (st_ff == ST_RXD) || ((st_ff == ST_TXD) && fd && rx_en);
	wire samp    = tick && (rx_half ? half_ff : !half_ff) && rx_act;
	wire drive   = (st_ff == ST_CMD) || (st_ff == ST_ADDR) || (st_ff == ST_TXD);
	wire [3:0] rx_src = rx_full ? rx_pipe_ff : io_sync_ff;

	// Byte-lane merge of a write into a register
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (be[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Buffer word of stream bit k; upper half forced when selected
	function [3:0] bword;
		input [9:0] k;
		input       hi;
		begin
			bword = {hi | k[8], k[7:5]};
		end
	endfunction

	// Bit position of stream bit k in its word, msb first per byte
	function [4:0] bpos;
		input [9:0] k;
		input       be;
		begin
			bpos = {(be ? ~k[4:3] : k[4:3]), ~k[2:0]};
		end
	endfunction

	// Stream bit k of a value of len+1 bits
	function vbit;
		input [63:0] v;
		input [9:0]  k;
		input [9:0]  len;
		input        be;
		reg   [9:0]  idx;
		begin
			idx = be ? (len - k) : {k[9:3], ~k[2:0]};
			vbit = v[idx[5:0]];
		end
	endfunction

	// First enabled phase strictly after state s
	function [3:0] next_ph;
		input [3:0] s;
		begin
			next_ph = ctrl_ff[`STP_CS_HOLD] ? ST_HOLD : ST_DONE;
			if (s < ST_RXD && rx_en && !(fd && tx_en))
				next_ph = ST_RXD;
			if (s < ST_TXD && tx_en)
				next_ph = ST_TXD;
			if (s < ST_DUMMY && dummy_en)
				next_ph = ST_DUMMY;
			if (s < ST_ADDR && addr_en)
				next_ph = ST_ADDR;
			if (s < ST_CMD && cmd_en)
				next_ph = ST_CMD;
		end
	endfunction

	// Length and lane count of the running phase
	always @*
	begin
		len_cur = 10'h000;
		w_cur = 3'd1;
		case (st_ff)
			ST_SETUP: len_cur = {2'b00, setup_time};
			ST_HOLD:  len_cur = {2'b00, hold_time};
			ST_DUMMY: len_cur = {2'b00, plen_ff[7:0]};
			ST_CMD:   len_cur = {6'h00, cmd_len};
			ST_ADDR:
			begin
				len_cur = {4'h0, ADDR_LEN_M1};
				w_cur = addr_w;
			end
			ST_TXD:
			begin
				len_cur = txlen_ff[9:0];
				w_cur = data_w;
			end
			ST_RXD:
			begin
				len_cur = rxlen_ff[9:0];
				w_cur = data_w;
			end
			default: len_cur = 10'h000;
		endcase
	end

	// Per-slot stream index and line; slot g goes to line w-1-g
	wire [9:0] sl_k  [0:3];
	wire [1:0] sl_ln [0:3];
	wire [3:0] sl_use;
	wire [3:0] sl_tb;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : slot
			localparam [9:0] OFS = g;
			localparam [2:0] GW = g;
			wire [2:0] ln = w_cur - GW - 3'd1;
			assign sl_k[g] = cnt_ff + OFS;
			assign sl_ln[g] = ln[1:0];
			assign sl_use[g] = GW < w_cur;
			assign sl_tb[g] = (st_ff == ST_CMD) ?
				vbit({48'h0, cmdcfg_ff[15:0]}, sl_k[g], len_cur, tx_be) :
				(st_ff == ST_ADDR) ? vbit(addr64, sl_k[g], len_cur, tx_be) :
				buf_ff[bword(sl_k[g], tx_hi)][bpos(sl_k[g], tx_be)];
		end
	endgenerate

	// Outgoing bits of the current cycle
	always @*
	begin
		tx_bits = 4'h0;
		for (j = 0; j < 4; j = j + 1)
			if (sl_use[j] && drive)
				tx_bits[sl_ln[j]] = sl_tb[j];
	end

	// Pin synchroniser: data lines come from outside the clock domain
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			io_meta_ff <= 4'h0;
			io_sync_ff <= 4'h0;
		end
		else
		begin
			io_meta_ff <= spi_io_in;
			io_sync_ff <= io_meta_ff;
		end
	end

	// Sequencer, chip select and serial clock
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			st_ff <= ST_IDLE;
			cnt_ff <= 10'h000;
			half_ff <= 1'b0;
			div_ff <= 8'h00;
			spi_sclk <= 1'b0;
			spi_cs_n <= 1'b1;
		end
		else if (st_ff == ST_IDLE)
		begin
			div_ff <= 8'h00;
			half_ff <= 1'b0;
			cnt_ff <= 10'h000;
			if (go)
			begin
				spi_cs_n <= 1'b0;
				if (ctrl_ff[`STP_CS_SETUP] && !fd)
					st_ff <= ST_SETUP;
				else
					st_ff <= next_ph(ST_SETUP);
			end
		end
		else if (st_ff == ST_DONE)
		begin
			spi_cs_n <= 1'b1;
			st_ff <= ST_IDLE;
		end
		else if (tick)
		begin
			div_ff <= 8'h00;
			half_ff <= ~half_ff;
			spi_sclk <= clocked & ~half_ff; // Rises mid-cycle, falls at its end
			if (half_ff)
			begin
				if (last)
				begin
					cnt_ff <= 10'h000;
					st_ff <= (st_ff == ST_HOLD) ? ST_DONE : next_ph(st_ff);
				end
				else
					cnt_ff <= cnt_ff + {7'h00, w_cur};
			end
		end
		else
			div_ff <= div_ff + 8'h01;
	end

	// Data line drivers with the selected output delay
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			spi_io_out <= 4'h0;
			spi_io_oe <= 4'h0;
			pipe_ff <= 4'h0;
		end
		else
		begin
			if (tick && half_ff)
				pipe_ff <= tx_bits;
			if (tx_full)
				spi_io_out <= pipe_ff;
			else if (!tx_half || half_ff)
				spi_io_out <= tx_bits;
			if (!drive)
				spi_io_oe <= 4'h0;
			else if (w_cur == 3'd4)
				spi_io_oe <= 4'hf;
			else if (w_cur == 3'd2)
				spi_io_oe <= 4'h3;
			else
				spi_io_oe <= 4'h1;
		end
	end

	// Bus acknowledge and read data
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			ack_ff <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= bus_req & ~ack_ff;
			if (avs_read && !ack_ff)
				avs_readdata <= nxt_rdata;
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		if (widx[5:4] == `STP_BUF_SEL)
			nxt_rdata = buf_ff[widx[3:0]];
		else
			case ({widx, 2'b00})
				`STP_OFF_GO:     nxt_rdata[`STP_GO_BIT] = busy;
				`STP_OFF_CTRL:   nxt_rdata = ctrl_ff & `STP_CTRL_MASK;
				`STP_OFF_PLEN:   nxt_rdata = (plen_ff & `STP_PLEN_MASK)
					| {ADDR_LEN_M1, 26'h0};
				`STP_OFF_CMDCFG: nxt_rdata = cmdcfg_ff & `STP_CMDCFG_MASK;
				`STP_OFF_TXLEN:  nxt_rdata = txlen_ff & `STP_LEN_MASK;
				`STP_OFF_RXLEN:  nxt_rdata = rxlen_ff & `STP_LEN_MASK;
				`STP_OFF_STATUS: nxt_rdata = status_ff;
				`STP_OFF_ADDR:   nxt_rdata = addr_ff;
				`STP_OFF_TIMING: nxt_rdata = timing_ff & `STP_TIM_MASK;
				default:         nxt_rdata = 32'h0000_0000;
			endcase
	end

	// Register writes; masks keep reserved bits at zero
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrl_ff <= `STP_CTRL_RST;
			plen_ff <= 32'h0000_0000;
			cmdcfg_ff <= 32'h0000_0000;
			txlen_ff <= 32'h0000_0000;
			rxlen_ff <= 32'h0000_0000;
			status_ff <= 32'h0000_0000;
			addr_ff <= 32'h0000_0000;
			timing_ff <= `STP_TIM_RST;
		end
		else
		begin
			if (wr && {widx, 2'b00} == `STP_OFF_STATUS)
				status_ff <= merge(status_ff, avs_writedata, avs_byteenable);
			if (cfg_wr)
				case ({widx, 2'b00})
					`STP_OFF_CTRL: ctrl_ff <= merge(ctrl_ff, avs_writedata,
						avs_byteenable) & `STP_CTRL_MASK;
					`STP_OFF_PLEN: plen_ff <= merge(plen_ff, avs_writedata,
						avs_byteenable) & `STP_PLEN_MASK;
					`STP_OFF_CMDCFG: cmdcfg_ff <= merge(cmdcfg_ff, avs_writedata,
						avs_byteenable) & `STP_CMDCFG_MASK;
					`STP_OFF_TXLEN: txlen_ff <= merge(txlen_ff, avs_writedata,
						avs_byteenable) & `STP_LEN_MASK;
					`STP_OFF_RXLEN: rxlen_ff <= merge(rxlen_ff, avs_writedata,
						avs_byteenable) & `STP_LEN_MASK;
					`STP_OFF_ADDR: addr_ff <= merge(addr_ff, avs_writedata,
						avs_byteenable);
					`STP_OFF_TIMING: timing_ff <= merge(timing_ff, avs_writedata,
						avs_byteenable) & `STP_TIM_MASK;
					default: addr_ff <= addr_ff;
				endcase
		end
	end

	// Data buffer: bus writes when idle, received bits while running
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			for (r = 0; r < 16; r = r + 1)
				buf_ff[r] <= 32'h0000_0000;
			rx_pipe_ff <= 4'h0;
		end
		else
		begin
			if (cfg_wr && widx[5:4] == `STP_BUF_SEL)
				buf_ff[widx[3:0]] <= merge(buf_ff[widx[3:0]], avs_writedata,
					avs_byteenable);
			if (samp)
			begin
				rx_pipe_ff <= io_sync_ff; // One-cycle incoming delay source
				for (r = 0; r < 4; r = r + 1)
					if (sl_use[r] && sl_k[r] <= rxlen_ff[9:0])
						buf_ff[bword(sl_k[r], rx_hi)][bpos(sl_k[r], rx_be)] <=
							(w_cur == 3'd1) ? rx_src[three_wire ? 0 : 1]
							: rx_src[sl_ln[r]];
			end
		end
	end

endmodule // stp_spi_sequencer

`default_nettype wire

// *** stp_seq_chk.sv ***
// Port assertions of the SPI transaction sequencer
`include "stp_defs.vh"
`default_nettype none
module stp_seq_chk #(
	parameter ADDR_BITS = 24
) (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic        spi_sclk,
	input wire logic        spi_cs_n,
	input wire logic [3:0]  spi_io_out,
	input wire logic [3:0]  spi_io_oe,
	input wire logic [3:0]  spi_io_in,
	input wire logic        busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Any bus request, read or write
	wire req = avs_read | avs_write;
	// Start request as the slave takes it
	wire go_taken = avs_write & ~avs_waitrequest & (avs_address == `STP_OFF_GO)
		& avs_writedata[`STP_GO_BIT] & avs_byteenable[2] & ~busy;

	AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest)
		else $error("no wait cycle at start of access");
	AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("access longer than one wait cycle");
	AST_RD_LOAD: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data changed without a read");
	AST_CS_IDLE: assert property (spi_cs_n |-> !spi_sclk && spi_io_oe == 4'h0)
		else $error("link active while deselected");
	AST_BUSY_CS: assert property (!busy |-> spi_cs_n)
		else $error("chip select low while idle");
	AST_GO_START: assert property (go_taken |=> !spi_cs_n && busy)
		else $error("start request not followed by select");
	AST_CS_FALL: assert property ($fell(spi_cs_n) |-> $past(avs_write))
		else $error("select without a start request");
	// Bench keeps the default divider of four core cycles per half
	AST_SCLK_HIGH: assert property ($rose(spi_sclk) |=> spi_sclk [*3] ##1 !spi_sclk)
		else $error("serial clock high time wrong");
	AST_DATA_SET: assert property ($rose(spi_sclk) |-> $stable(spi_io_out))
		else $error("data moved at serial clock rise");

	cover property ($fell(spi_cs_n));
	cover property ($rose(spi_sclk));
	cover property (avs_read && !avs_waitrequest);
endmodule // stp_seq_chk

bind stp_spi_sequencer stp_seq_chk #(.ADDR_BITS(ADDR_BITS)) chk_u (
	.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
	.avs_readdata(avs_readdata), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
	.spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe), .spi_io_in(spi_io_in), .busy(busy));
`default_nettype wire

// *** stp_slave_model.sv ***
// Behavioural SPI slave standing on the far side of the link
`default_nettype none
module stp_slave_model (
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic [3:0]  spi_io_out,
	input  wire logic [3:0]  spi_io_oe,
	input  wire logic [31:0] reply,
	output var  logic [3:0]  drv,
	output var  logic [63:0] cap,
	output var  int          rise_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] idx = 5'h0;
	initial drv = 4'h0;
	// New frame: restart counts, present first reply bit
	always @(negedge spi_cs_n)
	begin
		idx = 5'h0;
		rise_count = 0;
		cap = 64'h0;
		drv = {4{reply[31]}};
	end
	// Count clocks and capture line 0 while the master drives it
	always @(posedge spi_sclk)
		if (!spi_cs_n)
		begin
			rise_count++;
			if (spi_io_oe[0])
				cap = {cap[62:0], spi_io_out[0]};
		end
	// Reply moves on the falling edge, half a cycle before sampling
	always @(negedge spi_sclk)
		if (!spi_cs_n)
		begin
			idx++;
			drv = {4{reply[~idx]}};
		end
	// Deselected lines show garbage, never the last bit
	always @(posedge spi_cs_n)
		drv = ~drv;
endmodule // stp_slave_model
`default_nettype wire

// *** spi_transaction_phase_control_bench.sv ***
// Self-checking bench of the SPI transaction sequencer
`include "stp_defs.vh"
`default_nettype none
module spi_transaction_phase_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ADDR_BITS = 24;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] reply = 32'h0;
	logic [31:0] q;
	wire         avs_waitrequest;
	wire  [31:0] avs_readdata;
	wire         spi_sclk;
	wire         spi_cs_n;
	wire         busy;
	wire  [3:0]  spi_io_out;
	wire  [3:0]  spi_io_oe;
	wire  [3:0]  drv;
	wire  [3:0]  spi_io_in;
	wire  [63:0] cap;
	int          rise_count;
	int          bad_count = 0;
	int          check_count = 0;
	int          cs_len = 0;
	int          base;
	logic [31:0] mctl [5] = '{32'h0, 32'h4000, 32'h8000, 32'h2000, 32'h1000};
	int          mexp [5] = '{40, 20, 10, 28, 32};

	always #25 core_clk = ~core_clk;
	// Line level: whoever enables drives
	assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & drv);
	// Length of each select window in core cycles
	always @(posedge core_clk)
		if (spi_cs_n === 1'b0)
			cs_len <= cs_len + 1;

	stp_spi_sequencer #(.ADDR_BITS(ADDR_BITS)) dut_u (.core_clk(core_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_io_out(spi_io_out),
		.spi_io_oe(spi_io_oe), .spi_io_in(spi_io_in), .busy(busy));
	stp_slave_model slave_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe), .reply(reply), .drv(drv),
		.cap(cap), .rise_count(rise_count));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= ~rd;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n == 50)
			bad_count++;
		// Taken at the edge that sees waitrequest low, then released
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b1, a, 32'h0);
		check(name, exp, q);
	endtask
	task automatic go(input logic [31:0] ctl);
		wr(`STP_OFF_CTRL, ctl);
		cs_len = 0;
		wr(`STP_OFF_GO, 32'h1 << `STP_GO_BIT);
	endtask
	task automatic idle;
		int n;
		n = 0;
		@(negedge core_clk);
		while (busy !== 1'b0 && n < 4000)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n == 4000)
			bad_count++;
	endtask
	task automatic xfer(input logic [31:0] ctl);
		go(ctl);
		idle;
	endtask

	// Hang guard, well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		end_of_test;
	end

	// Test sequence
	initial
	begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		rd(`STP_OFF_CTRL, `STP_CTRL_RST, "ctrl reset");
		rd(`STP_OFF_TIMING, `STP_TIM_RST, "timing reset");
		rd(8'h40, 32'h0, "unmapped");
		wr(`STP_OFF_PLEN, 32'hffff_ffff);
		rd(`STP_OFF_PLEN, (32'(ADDR_BITS - 1) << `STP_ADDR_LEN_LSB) | 32'hff, "plen");
		wr(`STP_OFF_STATUS, 32'h5a5a_c3c3);
		avs_byteenable <= 4'h1;
		wr(`STP_OFF_STATUS, 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		rd(`STP_OFF_STATUS, 32'h5a5a_c3ff, "status");
		// Command bit count and byte order
		wr(`STP_OFF_CMDCFG, 32'hf000_12a5);
		xfer(32'h8000_0800);
		check("cmd clocks", 16, rise_count);
		check("cmd be", 16'h12a5, cap[15:0]);
		xfer(32'h8000_0000);
		check("cmd le", 16'ha512, cap[15:0]);
		// Select setup and hold against a plain window
		wr(`STP_OFF_CMDCFG, 32'h7000_00a5);
		xfer(32'h8000_0000);
		base = cs_len;
		check("cmd8 clocks", 8, rise_count);
		wr(`STP_OFF_TIMING, 32'h0004_0003);
		xfer(32'h8000_0020);
		check("setup", base + 32, cs_len);
		wr(`STP_OFF_TIMING, 32'h0004_0200);
		xfer(32'h8000_0010);
		check("hold", base + 24, cs_len);
		// Phase order and buffer halves
		wr(8'h80, 32'h4433_2211);
		wr(8'ha0, 32'h8877_6655);
		wr(`STP_OFF_TXLEN, 32'h7);
		xfer(32'h8800_0000);
		check("cmd then tx", 16'ha511, cap[15:0]);
		xfer(32'h8800_0800);
		check("tx be", 16'ha544, cap[15:0]);
		wr(`STP_OFF_TXLEN, 32'hf);
		xfer(32'h0a00_0000);
		check("tx hi", 16'h5566, cap[15:0]);
		check("tx clocks", 16, rise_count);
		// Control write while busy is dropped
		go(32'h0800_0000);
		wr(`STP_OFF_CTRL, 32'h0);
		idle;
		rd(`STP_OFF_CTRL, 32'h0800_0000, "ctrl busy");
		// Receive into upper half, big-endian
		wr(8'ha0, 32'h0);
		reply = 32'h9c3a_0000;
		wr(`STP_OFF_RXLEN, 32'hf);
		xfer(32'h1100_0400);
		check("rx clocks", 16, rise_count);
		rd(8'ha0, 32'h9c3a_0000, "rx hi be");
		// Full duplex ignores setup, one shared phase
		wr(8'ha0, 32'h0);
		wr(`STP_OFF_TXLEN, 32'h7);
		wr(`STP_OFF_RXLEN, 32'h7);
		wr(`STP_OFF_TIMING, 32'h0004_0003);
		xfer(32'h1900_0021);
		check("fd clocks", 8, rise_count);
		check("fd no setup", base, cs_len);
		rd(8'ha0, 32'h0000_009c, "fd rx");
		wr(`STP_OFF_TIMING, `STP_TIM_RST);
		// Three-wire receive on the shared line
		wr(8'h80, 32'h0);
		reply = 32'h6e00_0000;
		xfer(32'h1001_0000);
		rd(8'h80, 32'h0000_006e, "three wire");
		// Address length and order
		wr(`STP_OFF_ADDR, 32'h00ab_cdef);
		xfer(32'h4000_0800);
		check("addr clocks", 24, rise_count);
		check("addr be", 24'habcdef, cap[23:0]);
		// Line widths of address and data
		wr(`STP_OFF_TXLEN, 32'hf);
		for (int i = 0; i < 5; i++)
		begin
			xfer(32'h4800_0000 | mctl[i]);
			check("multi line clocks", mexp[i], rise_count);
		end
		// Dummy length, free and gated clock
		wr(`STP_OFF_PLEN, 32'h4);
		xfer(32'h2000_0000);
		check("dummy clocks", 5, rise_count);
		xfer(32'h2400_0000);
		check("dummy gated", 0, rise_count);
		end_of_test;
	end
endmodule // spi_transaction_phase_control_bench
`default_nettype wire
